//--- logic/tcs_defs.svh
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
// register indices; byte address is four times the index
`define TCS_IDX_T0_LOW 10'h08A
`define TCS_IDX_CLK_SEL 10'h08E
`define TCS_IDX_MODE_CTL 10'h08F
`define TCS_RST_T0_LOW 8'h00
`define TCS_RST_CLK_SEL 8'h00
`define TCS_RST_MODE_CTL 6'h00
// clock select fields
`define TCS_CS_T3_HI 7
`define TCS_CS_T3_LO 6
`define TCS_CS_T2_HI 5
`define TCS_CS_T2_LO 4
`define TCS_CS_T1 3
`define TCS_CS_T0 2
`define TCS_CS_PRE_HI 1
`define TCS_CS_PRE_LO 0
// mode control fields
`define TCS_MC_T0_CNT 0
`define TCS_MC_T1_CNT 1
`define TCS_MC_T2_SPLIT 2
`define TCS_MC_T3_SPLIT 3
`define TCS_MC_T2_ALT 4
`define TCS_MC_T3_ALT 5
// divider terminal counts
`define TCS_DIV_BASE_LAST 6'h2F
`define TCS_EXT_DIV_LAST 3'h7
`endif

//--- logic/tcs_pkg.sv
package tcs_pkg;
    typedef enum logic [1:0] {
        PRE_DIV12,
        PRE_DIV4,
        PRE_DIV48,
        PRE_EXT8
    } tcs_prescale_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_DONE
    } tcs_bus_state_t;

    typedef struct packed {
        logic [5:0] baseCnt;
        logic [2:0] extCnt;
        logic extSync1;
        logic extSync2;
        logic extPrev;
        logic t0Prev;
        logic t1Prev;
        logic [7:0] clkSel;
        logic [5:0] modeCtl;
        logic [7:0] t0Low;
        tcs_bus_state_t busState;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic prescaleTick;
        logic tmr0Tick;
        logic tmr1Tick;
        logic tmr2LoTick;
        logic tmr2HiTick;
        logic tmr3LoTick;
        logic tmr3HiTick;
        logic tmr0LowCarry;
    } tcs_state_t;
endpackage

//--- logic/tcs_timer_clock_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_timer_clock_select (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClk,
    input wire logic tmr0Pin,
    input wire logic tmr1Pin,
    output logic prescaleTick,
    output logic tmr0Tick,
    output logic tmr1Tick,
    output logic tmr2LoTick,
    output logic tmr2HiTick,
    output logic tmr3LoTick,
    output logic tmr3HiTick,
    output logic tmr0LowCarry,
    output logic [7:0] tmr0CountLow
);
    tcs_pkg::tcs_state_t s_q;
    tcs_pkg::tcs_state_t s_d;

    always_comb begin
        logic div4;
        logic div12;
        logic div48;
        logic ext8;
        logic preSel;
        logic alt2;
        logic alt3;
        logic t0Fall;
        logic t1Fall;
        logic t0Adv;
        logic t1Adv;
        logic [9:0] idx;
        logic mapped;
        logic [31:0] rd;
        div4 = 1'b0;
        div12 = 1'b0;
        div48 = 1'b0;
        ext8 = 1'b0;
        preSel = 1'b0;
        alt2 = 1'b0;
        alt3 = 1'b0;
        t0Fall = 1'b0;
        t1Fall = 1'b0;
        t0Adv = 1'b0;
        t1Adv = 1'b0;
        idx = paddr[11:2];
        mapped = 1'b0;
        rd = 32'h00000000;
        s_d = s_q;

        // one shared base counter yields /4, /12 and /48 phase-aligned
        // the counter runs free, so a prescale change takes effect without a restart
        // but the first period after a change may be short
        if (s_q.baseCnt == `TCS_DIV_BASE_LAST) begin
            s_d.baseCnt = 6'h00;
        end else begin
            s_d.baseCnt = s_q.baseCnt + 6'h01;
        end
        // taps decoded from one counter keep the three rates in a fixed phase
        div4 = (s_q.baseCnt[1:0] == 2'h3);
        div12 = (s_q.baseCnt == 6'h0B) || (s_q.baseCnt == 6'h17) ||
                (s_q.baseCnt == 6'h23) || (s_q.baseCnt == 6'h2F);
        div48 = (s_q.baseCnt == `TCS_DIV_BASE_LAST);

        // external clock: two-stage sync, then edge detect on the synced copy
        s_d.extSync1 = extClk;
        s_d.extSync2 = s_q.extSync1;
        s_d.extPrev = s_q.extSync2;
        // only the second stage is read, so a metastable first stage never reaches logic
        // the external clock must stay below half the system clock or edges are lost
        // the divide-by-8 counter is not cleared on a mode change
        if (s_q.extSync2 && !s_q.extPrev) begin
            s_d.extCnt = s_q.extCnt + 3'h1;
            ext8 = (s_q.extCnt == `TCS_EXT_DIV_LAST);
        end

        case (tcs_pkg::tcs_prescale_t'(s_q.clkSel[`TCS_CS_PRE_HI:`TCS_CS_PRE_LO]))
            tcs_pkg::PRE_DIV12: begin
                preSel = div12;
            end
            tcs_pkg::PRE_DIV4: begin
                preSel = div4;
            end
            tcs_pkg::PRE_DIV48: begin
                preSel = div48;
            end
            tcs_pkg::PRE_EXT8: begin
                preSel = ext8;
            end
            default: begin
                preSel = 1'b0;
            end
        endcase

        // timers 2 and 3 never see the shared prescale field
        if (s_q.modeCtl[`TCS_MC_T2_ALT]) begin
            alt2 = ext8;
        end else begin
            alt2 = div12;
        end
        if (s_q.modeCtl[`TCS_MC_T3_ALT]) begin
            alt3 = ext8;
        end else begin
            alt3 = div12;
        end

        // pins are synchronous; falling edge from one stored sample
        s_d.t0Prev = tmr0Pin;
        s_d.t1Prev = tmr1Pin;
        t0Fall = s_q.t0Prev && !tmr0Pin;
        t1Fall = s_q.t1Prev && !tmr1Pin;

        // system clock choice is a constant enable; prescaler only when chosen
        if (s_q.modeCtl[`TCS_MC_T0_CNT]) begin
            t0Adv = t0Fall;
        end else begin
            if (s_q.clkSel[`TCS_CS_T0]) begin
                t0Adv = 1'b1;
            end else begin
                t0Adv = preSel;
            end
        end
        if (s_q.modeCtl[`TCS_MC_T1_CNT]) begin
            t1Adv = t1Fall;
        end else begin
            if (s_q.clkSel[`TCS_CS_T1]) begin
                t1Adv = 1'b1;
            end else begin
                t1Adv = preSel;
            end
        end

        s_d.prescaleTick = preSel;
        s_d.tmr0Tick = t0Adv;
        s_d.tmr1Tick = t1Adv;
        if (s_q.clkSel[`TCS_CS_T2_LO]) begin
            s_d.tmr2LoTick = 1'b1;
        end else begin
            s_d.tmr2LoTick = alt2;
        end
        if (s_q.clkSel[`TCS_CS_T3_LO]) begin
            s_d.tmr3LoTick = 1'b1;
        end else begin
            s_d.tmr3LoTick = alt3;
        end
        // unsplit: the high byte follows the low-byte clock choice
        if (s_q.modeCtl[`TCS_MC_T2_SPLIT]) begin
            if (s_q.clkSel[`TCS_CS_T2_HI]) begin
                s_d.tmr2HiTick = 1'b1;
            end else begin
                s_d.tmr2HiTick = alt2;
            end
        end else begin
            s_d.tmr2HiTick = s_d.tmr2LoTick;
        end
        if (s_q.modeCtl[`TCS_MC_T3_SPLIT]) begin
            if (s_q.clkSel[`TCS_CS_T3_HI]) begin
                s_d.tmr3HiTick = 1'b1;
            end else begin
                s_d.tmr3HiTick = alt3;
            end
        end else begin
            s_d.tmr3HiTick = s_d.tmr3LoTick;
        end

        s_d.tmr0LowCarry = 1'b0;
        if (t0Adv) begin
            s_d.t0Low = s_q.t0Low + 8'h01;
            // carry rides with the wrap so a downstream high byte steps in the same cycle
            if (s_q.t0Low == 8'hFF) begin
                s_d.tmr0LowCarry = 1'b1;
            end else begin
                s_d.tmr0LowCarry = 1'b0;
            end
        end

        // register decode
        case (idx)
            `TCS_IDX_T0_LOW: begin
                mapped = 1'b1;
                rd = {24'h000000, s_q.t0Low};
            end
            `TCS_IDX_CLK_SEL: begin
                mapped = 1'b1;
                rd = {24'h000000, s_q.clkSel};
            end
            `TCS_IDX_MODE_CTL: begin
                mapped = 1'b1;
                rd = {26'h0000000, s_q.modeCtl};
            end
            default: begin
                mapped = 1'b0;
                rd = 32'h00000000;
            end
        endcase

        // one wait state: pready rises in the second access cycle
        case (s_q.busState)
            tcs_pkg::BUS_IDLE: begin
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
                if (psel && penable) begin
                    s_d.busState = tcs_pkg::BUS_WAIT;
                    s_d.pready = 1'b1;
                    s_d.pslverr = !mapped;
                    s_d.prdata = (pwrite || !mapped) ? 32'h00000000 : rd;
                end
            end
            tcs_pkg::BUS_WAIT: begin
                // write lands on the edge where pready is sampled high
                if (pwrite && mapped) begin
                    case (idx)
                        `TCS_IDX_T0_LOW: begin
                            // software load beats a same-cycle increment
                            s_d.t0Low = pwdata[7:0];
                            s_d.tmr0LowCarry = 1'b0;
                        end
                        `TCS_IDX_CLK_SEL: begin
                            s_d.clkSel = pwdata[7:0];
                        end
                        `TCS_IDX_MODE_CTL: begin
                            // upper data bits are dropped; they read back as zero
                            s_d.modeCtl = pwdata[5:0];
                        end
                        default: begin
                            s_d.clkSel = s_q.clkSel;
                        end
                    endcase
                end
                s_d.busState = tcs_pkg::BUS_DONE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
                s_d.prdata = 32'h00000000;
            end
            tcs_pkg::BUS_DONE: begin
                // gap cycle keeps a back-to-back setup from being seen as access
                s_d.busState = tcs_pkg::BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
            default: begin
                s_d.busState = tcs_pkg::BUS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.clkSel <= `TCS_RST_CLK_SEL;
            s_q.modeCtl <= `TCS_RST_MODE_CTL;
            s_q.t0Low <= `TCS_RST_T0_LOW;
            s_q.busState <= tcs_pkg::BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign prescaleTick = s_q.prescaleTick;
    assign tmr0Tick = s_q.tmr0Tick;
    assign tmr1Tick = s_q.tmr1Tick;
    assign tmr2LoTick = s_q.tmr2LoTick;
    assign tmr2HiTick = s_q.tmr2HiTick;
    assign tmr3LoTick = s_q.tmr3LoTick;
    assign tmr3HiTick = s_q.tmr3HiTick;
    assign tmr0LowCarry = s_q.tmr0LowCarry;
    assign tmr0CountLow = s_q.t0Low;
endmodule
`default_nettype wire

//--- tb/tcs_timer_clock_select_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic prescaleTick,
    input wire logic tmr0Tick,
    input wire logic tmr0LowCarry,
    input wire logic [7:0] tmr0CountLow
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable;
    endsequence
    ready_next_a: assert property (setupS ##1 accessS |=> pready) else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("data leak");
    pre_pulse_a: assert property (prescaleTick |=> !prescaleTick) else $error("wide tick");
    count_step_a: assert property (!psel && !$past(psel) |->
        tmr0CountLow == $past(tmr0CountLow) + {7'h00, tmr0Tick}) else $error("bad step");
    carry_wrap_a: assert property (tmr0LowCarry |-> tmr0Tick && tmr0CountLow == 8'h00)
        else $error("bad carry");
endmodule
bind tcs_timer_clock_select tcs_checker chk_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaleTick(prescaleTick), .tmr0Tick(tmr0Tick), .tmr0LowCarry(tmr0LowCarry),
    .tmr0CountLow(tmr0CountLow));
`default_nettype wire

//--- tb/tb_timer_clock_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"
module tb_timer_clock_select;
    localparam logic [11:0] A_T0 = `TCS_IDX_T0_LOW << 2;
    localparam logic [11:0] A_CS = `TCS_IDX_CLK_SEL << 2;
    localparam logic [11:0] A_MC = `TCS_IDX_MODE_CTL << 2;
    logic clk, rst, psel, penable, pwrite, extClk, tmr0Pin, tmr1Pin, pready, pslverr, er;
    logic prescaleTick, tmr0Tick, tmr1Tick, tmr2LoTick, tmr2HiTick, tmr3LoTick, tmr3HiTick;
    logic tmr0LowCarry;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] tmr0CountLow;
    int bad_count = 0;
    int checks = 0;
    tcs_timer_clock_select dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .extClk, .tmr0Pin, .tmr1Pin, .prescaleTick, .tmr0Tick,
        .tmr1Tick, .tmr2LoTick, .tmr2HiTick, .tmr3LoTick, .tmr3HiTick, .tmr0LowCarry,
        .tmr0CountLow);
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    // pins and external clock stop toggling 40 or more cycles before the window ends so late ticks still land
    task run(input logic [7:0] mode, input logic [7:0] sel, input int e[7]);
        int c[7];
        logic [6:0] v;
        apb(1'b1, A_MC, {24'h000000, mode});
        apb(1'b1, A_CS, {24'h000000, sel});
        c = '{default: 0};
        repeat (4) @(posedge clk);
        for (int i = 0; i < 480; i++) begin
            @(posedge clk);
            if (i < 440 && i % 5 == 0)
                tmr0Pin <= !tmr0Pin;
            if (i < 440 && i % 10 == 0)
                tmr1Pin <= !tmr1Pin;
            if (i < 432 && i % 3 == 0)
                extClk <= !extClk;
            @(negedge clk);
            v = {tmr3HiTick, tmr3LoTick, tmr2HiTick, tmr2LoTick, tmr1Tick, tmr0Tick, prescaleTick};
            for (int k = 0; k < 7; k++)
                c[k] += (v[k] === 1'b1);
        end
        for (int k = 0; k < 7; k++)
            check(c[k], e[k]);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, extClk} = '0;
        tmr0Pin = 1'b1;
        tmr1Pin = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, A_T0, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_CS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check({31'h0, er}, 32'h1);
        run(8'h00, 8'h00, '{40, 40, 40, 40, 40, 40, 40});
        run(8'h00, 8'h01, '{120, 120, 120, 40, 40, 40, 40});
        run(8'h00, 8'h02, '{10, 10, 10, 40, 40, 40, 40});
        run(8'h00, 8'hFC, '{40, 480, 480, 480, 480, 480, 480});
        run(8'h0C, 8'h50, '{40, 40, 40, 480, 40, 480, 40});
        run(8'h00, 8'hA0, '{40, 40, 40, 40, 40, 40, 40});
        run(8'h03, 8'h0C, '{40, 44, 22, 40, 40, 40, 40});
        run(8'h30, 8'h03, '{9, 9, 9, 9, 9, 9, 9});
        apb(1'b1, A_T0, 32'hFFFFFFA5);
        apb(1'b0, A_T0, 32'h0);
        check(rd, 32'h000000A5);
        check({24'h0, tmr0CountLow}, 32'h000000A5);
        tally_and_finish;
    end
endmodule
`default_nettype wire
